// [design/fpec_ctrl.sv]
// Flash program and erase sequencer with a Wishbone register slave.
`timescale 1ns/1ps
// ------------------------------------------------------------
// Summary of operation
// - Start refused unless unlock came just before.
// - Start bit launches; hardware clears it when done.
// - Processor held stalled while an operation runs.
// - Permit bit gates every program and erase.
// - Fault flag set on any improper start.
// - Erase select picks erase or program meaning.
// - Code 1111 bulk erase, serial mode only.
// - Code 0011 programs one word.
// - Code 0010 erases one eight-row block.
// - Code 0001 programs one row from latches.
// - Other codes perform no flash operation.
// - Control bits cleared only by power-on reset.
// - Rows hold 64 words; eight rows per block.
// - Table writes only fill the holding latches.
// - Rows and blocks aligned, low bits ignored.
// ------------------------------------------------------------
module fpec_ctrl
	import fpec_pkg::*;
#(
	parameter int ROW_WORDS = ROW_WORDS_DEF
)
(
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	input  wire logic               sys_rst_i,
	input  wire logic               wb_cyc_i,
	input  wire logic               wb_stb_i,
	input  wire logic               wb_we_i,
	input  wire logic [7:0]         wb_adr_i,
	input  wire logic [3:0]         wb_sel_i,
	input  wire logic [31:0]        wb_dat_i,
	output logic                    wb_ack_o,
	output logic      [31:0]        wb_dat_o,
	input  wire logic               serial_programming_mode_i,
	input  wire logic               flash_done_i,
	input  wire logic               flash_err_i,
	output logic                    flash_req_o,
	output logic      [1:0]         flash_cmd_o,
	output logic      [PROG_AW-1:0] flash_addr_o,
	output logic      [INSTR_W-1:0] flash_wdata_o,
	output logic                    cpu_stall_o
);

	// ------------------------------------------------------------
	// Parameter check
	// ------------------------------------------------------------
	generate
		if (ROW_WORDS != (2 ** ROW_IDX_W))
		begin : g_bad_row
			$error("row size must match the latch index width");
		end
	endgenerate

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic                 wr;
		logic                 permit;
		logic                 fault;
		logic                 erase;
		logic [OPSEL_W-1:0]   opsel;
		logic [7:0]           page;
		logic [15:0]          laddr;
		fpec_key_e            key;
		fpec_op_e             op;
		logic                 row;
		logic [ROW_IDX_W-1:0] idx;
		logic                 ack;
		logic [31:0]          dat;
		logic                 req;
		logic [1:0]           cmd;
		logic [PROG_AW-1:0]   faddr;
		logic [INSTR_W-1:0]   fdata;
	} fpec_state_s;

	fpec_state_s          q;
	fpec_state_s          d;
	logic [7:0]           word_adr;
	logic                 wr_acc;
	logic                 attempt;
	logic                 start;
	logic                 nop;
	logic                 lat_we;
	logic [15:0]          ctrl_rd;
	logic [31:0]          nw;
	logic [31:0]          rd;
	logic [INSTR_W-1:0]   lat_rdata;
	logic [PROG_AW-1:0]   tgt;

	function automatic logic [31:0] be_merge(
		input logic [31:0] old_v,
		input logic [31:0] new_v,
		input logic [3:0]  sel
	);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++)
		begin
			if (sel[b])
			begin
				r[8*b +: 8] = new_v[8*b +: 8];
			end
		end
		return r;
	endfunction

	fpec_latch_mem #(
		.WIDTH (INSTR_W),
		.DEPTH (ROW_WORDS),
		.AW    (ROW_IDX_W)
	) u_latch (
		.clk_i   (clk_i),
		.we_i    (lat_we),
		.waddr_i (q.laddr[ROW_ALIGN_BITS-1:1]),
		.wdata_i (wb_dat_i[INSTR_W-1:0]),
		.raddr_i (q.idx),
		.rdata_o (lat_rdata)
	);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb
	begin
		d        = q;
		d.req    = 1'b0;
		word_adr = {wb_adr_i[7:2], 2'b00};
		wr_acc   = wb_cyc_i & wb_stb_i & wb_we_i & q.ack;
		attempt  = 1'b0;
		start    = 1'b0;
		nop      = 1'b0;
		lat_we   = 1'b0;
		tgt      = {q.page, q.laddr};

		ctrl_rd                  = 16'h0000;
		ctrl_rd[CTRL_WR_BIT]     = q.wr;
		ctrl_rd[CTRL_PERMIT_BIT] = q.permit;
		ctrl_rd[CTRL_FAULT_BIT]  = q.fault;
		ctrl_rd[CTRL_ERASE_BIT]  = q.erase;
		ctrl_rd[OPSEL_LSB +: OPSEL_W] = q.opsel;
		nw = be_merge({16'h0000, ctrl_rd}, wb_dat_i, wb_sel_i);

		rd = 32'h0000_0000;
		case (word_adr)
			ADR_CTRL:  rd = {16'h0000, ctrl_rd};
			ADR_PAGE:  rd = {24'h00_0000, q.page};
			ADR_LADDR: rd = {16'h0000, q.laddr};
			ADR_STAT:
			begin
				rd[STAT_GOT_BIT]   = (q.key == KEY_GOT_FIRST);
				rd[STAT_ARMED_BIT] = (q.key == KEY_ARMED);
				rd[STAT_BUSY_BIT]  = q.wr;
			end
			default:   rd = 32'h0000_0000;
		endcase

		// Ack one cycle after the request; the write lands on the
		// edge where the master sees ack, so it acts exactly once.
		d.ack = wb_cyc_i & wb_stb_i & ~q.ack;
		d.dat = rd;

		// Register writes are refused while an operation runs; the
		// processor is stalled then, so only a stray master hits it.
		if (wr_acc && !q.wr)
		begin
			d.key = KEY_IDLE;
			case (word_adr)
				ADR_KEY:
				begin
					if (wb_sel_i[0] && wb_dat_i[7:0] == KEY_SECOND &&
						q.key == KEY_GOT_FIRST)
					begin
						d.key = KEY_ARMED;
					end
					else if (wb_sel_i[0] && wb_dat_i[7:0] == KEY_FIRST)
					begin
						d.key = KEY_GOT_FIRST;
					end
				end
				ADR_CTRL:
				begin
					d.permit = nw[CTRL_PERMIT_BIT];
					d.fault  = nw[CTRL_FAULT_BIT];
					d.erase  = nw[CTRL_ERASE_BIT];
					d.opsel  = nw[OPSEL_LSB +: OPSEL_W];
					attempt  = nw[CTRL_WR_BIT];
				end
				ADR_PAGE:
				begin
					d.page = nw[7:0];
				end
				ADR_LADDR:
				begin
					d.laddr = nw[15:0];
				end
				ADR_LDATA:
				begin
					// Latch load only; the array is not touched here.
					lat_we  = 1'b1;
					d.laddr = q.laddr + LADDR_STEP;
				end
				default:
				begin
					d.key = KEY_IDLE;
				end
			endcase
		end

		if (attempt)
		begin
			if (q.key == KEY_ARMED && nw[CTRL_PERMIT_BIT])
			begin
				start = 1'b1;
			end
			else
			begin
				d.fault = 1'b1;
			end
		end

		if (start)
		begin
			d.key   = KEY_IDLE;
			d.wr    = 1'b1;
			d.fault = 1'b0;
			d.row   = 1'b0;
			d.op    = OP_ISSUE;
			if (d.erase && d.opsel == CODE_BULK &&
				serial_programming_mode_i)
			begin
				d.cmd   = CMD_ERASE_BULK;
				d.faddr = '0;
			end
			else if (d.erase && d.opsel == CODE_PAGE)
			begin
				d.cmd   = CMD_ERASE_PAGE;
				d.faddr = tgt & BLK_MASK;
			end
			else if (!d.erase && d.opsel == CODE_WORD)
			begin
				d.cmd   = CMD_PROG_WORD;
				d.faddr = tgt;
				d.idx   = q.laddr[ROW_ALIGN_BITS-1:1];
				d.op    = OP_READ;
			end
			else if (!d.erase && d.opsel == CODE_ROW)
			begin
				d.cmd   = CMD_PROG_WORD;
				d.row   = 1'b1;
				d.faddr = tgt & ROW_MASK;
				d.idx   = '0;
				d.op    = OP_READ;
			end
			else
			begin
				nop  = 1'b1;
				d.op = OP_DONE;
			end
		end

		case (q.op)
			OP_IDLE:
			begin
			end
			OP_READ:
			begin
				d.op = OP_ISSUE;
			end
			OP_ISSUE:
			begin
				d.req   = 1'b1;
				d.fdata = lat_rdata;
				if (q.row)
				begin
					d.faddr = {q.faddr[PROG_AW-1:ROW_ALIGN_BITS],
						q.idx, 1'b0};
				end
				d.op = OP_WAIT;
			end
			OP_WAIT:
			begin
				if (flash_done_i)
				begin
					if (flash_err_i)
					begin
						d.fault = 1'b1;
					end
					if (q.row && q.idx != ROW_LAST && !flash_err_i)
					begin
						d.idx = q.idx + 6'h01;
						d.op  = OP_READ;
					end
					else
					begin
						d.op = OP_DONE;
					end
				end
			end
			OP_DONE:
			begin
				d.wr = 1'b0;
				d.op = OP_IDLE;
			end
			default:
			begin
				d.op = OP_IDLE;
			end
		endcase

		// A warm reset drops only the unlock progress.
		if (sys_rst_i)
		begin
			d.key = KEY_IDLE;
		end
	end

	// Only the power-on reset clears the control bits.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			q <= '0;
		end
		else
		begin
			q <= d;
		end
	end

	assign wb_ack_o      = q.ack;
	assign wb_dat_o      = q.dat;
	assign flash_req_o   = q.req;
	assign flash_cmd_o   = q.cmd;
	assign flash_addr_o  = q.faddr;
	assign flash_wdata_o = q.fdata;
	assign cpu_stall_o   = q.wr;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	a_start_key_used: assert property (
		@(posedge clk_i) disable iff (rst_i)
		$rose(q.wr) |-> $past(q.key) == KEY_ARMED)
		else $error("operation began without a fresh unlock");

	a_unlock_consumed: assert property (
		@(posedge clk_i) disable iff (rst_i)
		$rose(q.wr) |-> q.key == KEY_IDLE)
		else $error("unlock survived the start request");

	a_done_clears_wr: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(q.op == OP_WAIT && flash_done_i && !q.row) |-> ##2 !q.wr)
		else $error("start bit not cleared after completion");

	a_stall_while_busy: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(q.op != OP_IDLE) |-> cpu_stall_o)
		else $error("processor released during an operation");

	a_permit_refuses: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(attempt && !nw[CTRL_PERMIT_BIT]) |=> (!q.wr && q.fault))
		else $error("start accepted with operations inhibited");

	a_fault_no_key: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(attempt && q.key != KEY_ARMED) |=> (q.fault && !q.wr))
		else $error("bad start did not raise the fault flag");

	a_nop_no_request: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(start && nop) |=> (!flash_req_o && q.wr) ##1 !q.wr)
		else $error("no-operation code touched the array");

	a_cancel_partial: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(wr_acc && !q.wr && q.key == KEY_GOT_FIRST &&
			word_adr != ADR_KEY) |=> q.key == KEY_IDLE)
		else $error("partial unlock survived another write");

	a_block_aligned: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(flash_req_o && flash_cmd_o == CMD_ERASE_PAGE) |->
			(flash_addr_o & ~BLK_MASK) == '0)
		else $error("block erase address not aligned");

	a_row_req_follows: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(q.op == OP_READ) |=> ##1 (flash_req_o &&
			flash_cmd_o == CMD_PROG_WORD))
		else $error("latch read not followed by a program request");

	a_ack_single: assert property (
		@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held for more than one cycle");

endmodule

// [inc/fpec_pkg.sv]
// Constants and types shared by the flash sequencer and its latch memory.
package fpec_pkg;

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] ADR_CTRL  = 8'h00;
	localparam logic [7:0] ADR_KEY   = 8'h04;
	localparam logic [7:0] ADR_PAGE  = 8'h08;
	localparam logic [7:0] ADR_LADDR = 8'h0C;
	localparam logic [7:0] ADR_LDATA = 8'h10;
	localparam logic [7:0] ADR_STAT  = 8'h14;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int CTRL_WR_BIT     = 15;
	localparam int CTRL_PERMIT_BIT = 14;
	localparam int CTRL_FAULT_BIT  = 13;
	localparam int CTRL_ERASE_BIT  = 6;
	localparam int OPSEL_LSB       = 0;
	localparam int OPSEL_W         = 4;
	localparam int STAT_GOT_BIT    = 0;
	localparam int STAT_ARMED_BIT  = 1;
	localparam int STAT_BUSY_BIT   = 2;

	// ------------------------------------------------------------
	// Key values and operation codes
	// ------------------------------------------------------------
	localparam logic [7:0] KEY_FIRST  = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'hAA;
	localparam logic [3:0] CODE_BULK  = 4'hF;
	localparam logic [3:0] CODE_WORD  = 4'h3;
	localparam logic [3:0] CODE_PAGE  = 4'h2;
	localparam logic [3:0] CODE_ROW   = 4'h1;
	localparam logic [1:0] CMD_PROG_WORD  = 2'h0;
	localparam logic [1:0] CMD_ERASE_PAGE = 2'h1;
	localparam logic [1:0] CMD_ERASE_BULK = 2'h2;

	// ------------------------------------------------------------
	// Array geometry
	// ------------------------------------------------------------
	localparam int ROW_WORDS_DEF  = 64;
	localparam int ROW_IDX_W      = 6;
	localparam int ROW_ALIGN_BITS = 7;
	localparam int BLK_ALIGN_BITS = 10;
	localparam int PROG_AW        = 24;
	localparam int INSTR_W        = 24;
	localparam logic [ROW_IDX_W-1:0] ROW_LAST = 6'h3F;
	localparam logic [PROG_AW-1:0] ROW_MASK =
		~((24'h000001 << ROW_ALIGN_BITS) - 24'h000001);
	localparam logic [PROG_AW-1:0] BLK_MASK =
		~((24'h000001 << BLK_ALIGN_BITS) - 24'h000001);
	localparam logic [15:0] LADDR_STEP = 16'h0002;

	// ------------------------------------------------------------
	// State enumerations
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		KEY_IDLE,
		KEY_GOT_FIRST,
		KEY_ARMED
	} fpec_key_e;

	typedef enum logic [2:0] {
		OP_IDLE,
		OP_READ,
		OP_ISSUE,
		OP_WAIT,
		OP_DONE
	} fpec_op_e;

endpackage

// [design/fpec_latch_mem.sv]
// Row holding latches: one write port and a registered read port.
`timescale 1ns/1ps
module fpec_latch_mem
	import fpec_pkg::*;
#(
	parameter int WIDTH = INSTR_W,
	parameter int DEPTH = ROW_WORDS_DEF,
	parameter int AW    = ROW_IDX_W
)
(
	input  wire logic             clk_i,
	input  wire logic             we_i,
	input  wire logic [AW-1:0]    waddr_i,
	input  wire logic [WIDTH-1:0] wdata_i,
	input  wire logic [AW-1:0]    raddr_i,
	output logic      [WIDTH-1:0] rdata_o
);

	typedef struct packed {
		logic [WIDTH-1:0] rdata;
	} fpec_mem_s;

	generate
		if (DEPTH > (2 ** AW) || WIDTH < 1)
		begin : g_bad_size
			$error("latch memory depth does not fit its address");
		end
	endgenerate

	// The latches have no reset; they power up unknown.
	logic [WIDTH-1:0] mem [DEPTH];
	fpec_mem_s        q;
	fpec_mem_s        d;

	always_comb
	begin
		d       = q;
		d.rdata = mem[raddr_i];
	end

	always_ff @(posedge clk_i)
	begin
		q <= d;
		if (we_i)
		begin
			mem[waddr_i] <= wdata_i;
		end
	end

	assign rdata_o = q.rdata;

endmodule

// [tb/fpec_flash_model.sv]
// Behavioural flash array that answers the sequencer's requests.
`timescale 1ns/1ps
module fpec_flash_model
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        req_i,
	input  wire logic [1:0]  cmd_i,
	input  wire logic [23:0] addr_i,
	input  wire logic [23:0] wdata_i,
	input  wire logic        slow_i,
	input  wire logic        fail_i,
	output logic             done_o,
	output logic             err_o,
	output logic [15:0]      reqs_o,
	output logic [1:0]       cmd_o,
	output logic [23:0]      addr_o,
	output logic [23:0]      data_o
);
	logic [3:0] wait_q;
	logic       busy_q;

	// ----------------------------------------------------------------
	// Request record and completion
	// ----------------------------------------------------------------
	// A slow answer keeps the sequencer busy long enough to watch it.
	always_ff @(posedge clk_i)
	begin
		done_o <= 1'b0;
		if (rst_i)
		begin
			busy_q <= 1'b0;
			wait_q <= 4'h0;
			reqs_o <= 16'h0000;
		end
		else if (req_i)
		begin
			busy_q <= 1'b1;
			wait_q <= slow_i ? 4'h6 : 4'h0;
			reqs_o <= reqs_o + 16'h0001;
			cmd_o  <= cmd_i;
			addr_o <= addr_i;
			data_o <= wdata_i;
		end
		else if (busy_q)
		begin
			if (wait_q == 4'h0)
			begin
				busy_q <= 1'b0;
				done_o <= 1'b1;
			end
			else
				wait_q <= wait_q - 4'h1;
		end
	end

	// The error line means nothing outside a completion pulse.
	assign err_o = done_o & fail_i;
endmodule

// [tb/flash_program_erase_control_tb.sv]
// Self-checking bench for the flash program and erase sequencer.
`timescale 1ns/1ps
module flash_program_erase_control_tb;
	import fpec_pkg::*;
	logic        clk_i   = 1'b0;
	logic        rst_i   = 1'b1;
	logic        sys_rst = 1'b0;
	logic        cyc     = 1'b0;
	logic        stb     = 1'b0;
	logic        we      = 1'b0;
	logic [7:0]  adr     = 8'h00;
	logic [31:0] wdat    = 32'h0;
	logic        serial  = 1'b0;
	logic        slow    = 1'b0;
	logic        fail    = 1'b0;
	logic        ack, req, stall, done, err;
	logic [31:0] rdat, rd;
	logic [1:0]  cmd, mcmd;
	logic [23:0] addr, wdata, maddr, mdata;
	logic [15:0] reqs, base;
	int          mismatches      = 0;
	int          samples_checked = 0;

	always #50 clk_i = ~clk_i;

	fpec_ctrl uut (.clk_i(clk_i), .rst_i(rst_i), .sys_rst_i(sys_rst),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_ack_o(ack), .wb_dat_o(rdat),
		.serial_programming_mode_i(serial), .flash_done_i(done),
		.flash_err_i(err), .flash_req_o(req), .flash_cmd_o(cmd),
		.flash_addr_o(addr), .flash_wdata_o(wdata), .cpu_stall_o(stall));

	fpec_flash_model array (.clk_i(clk_i), .rst_i(rst_i), .req_i(req),
		.cmd_i(cmd), .addr_i(addr), .wdata_i(wdata), .slow_i(slow),
		.fail_i(fail), .done_o(done), .err_o(err), .reqs_o(reqs),
		.cmd_o(mcmd), .addr_o(maddr), .data_o(mdata));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic test_done();
		$display("Checks %0d, mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= d;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack !== 1'b1 && n < 20);
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 20)
		begin
			mismatches++;
			test_done();
		end
	endtask

	task automatic unlock();
		wb(1'b1, ADR_KEY, 32'h55);
		wb(1'b1, ADR_KEY, 32'hAA);
	endtask

	// Sets up the mode, optionally unlocks, starts and judges the result.
	task automatic op(input logic [15:0] c, input logic key,
		input logic [15:0] n, input logic [1:0] ec, input logic [23:0] ea,
		input logic flt);
		int t;
		t = 0;
		base = reqs;
		wb(1'b1, ADR_CTRL, {16'h0, c & 16'h7FFF});
		if (key)
			unlock();
		wb(1'b1, ADR_CTRL, {16'h0, c});
		@(posedge clk_i);
		chk({31'h0, stall}, {31'h0, (n != 0) | !flt});
		while (stall !== 1'b0 && t < 2000)
		begin
			@(posedge clk_i);
			t++;
		end
		if (t >= 2000)
		begin
			mismatches++;
			test_done();
		end
		chk({16'h0, reqs - base}, {16'h0, n});
		if (n != 0)
		begin
			chk({30'h0, mcmd}, {30'h0, ec});
			chk({8'h0, maddr}, {8'h0, ea});
		end
		wb(1'b0, ADR_CTRL, 32'h0);
		chk(rd, {16'h0, (c & 16'h5FFF) | (flt ? 16'h2000 : 16'h0)});
	endtask

	task automatic pulse_warm();
		@(posedge clk_i);
		sys_rst <= 1'b1;
		@(posedge clk_i);
		sys_rst <= 1'b0;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		wb(1'b0, ADR_CTRL, 32'h0);
		chk(rd, 32'h0);
		wb(1'b0, 8'h1C, 32'h0);
		chk(rd, 32'h0);
		$display("reset values done");
	endtask

	task automatic t_erase();
		slow <= 1'b1;
		wb(1'b1, ADR_PAGE, 32'h01);
		wb(1'b1, ADR_LADDR, 32'h0BCD);
		op(16'hC042, 1'b1, 16'h1, 2'h1, 24'h010800, 1'b0);
		op(16'hC042, 1'b0, 16'h0, 2'h1, 24'h0, 1'b1);
		slow <= 1'b0;
		$display("block erase done");
	endtask

	task automatic t_guard();
		op(16'hC042, 1'b0, 16'h0, 2'h1, 24'h0, 1'b1);
		op(16'h8042, 1'b1, 16'h0, 2'h1, 24'h0, 1'b1);
		wb(1'b1, ADR_CTRL, 32'h4042);
		wb(1'b1, ADR_KEY, 32'h55);
		wb(1'b0, ADR_STAT, 32'h0);
		chk(rd, 32'h1);
		wb(1'b1, ADR_PAGE, 32'h01);
		wb(1'b0, ADR_STAT, 32'h0);
		chk(rd, 32'h0);
		wb(1'b1, ADR_KEY, 32'hAA);
		wb(1'b1, ADR_CTRL, 32'hC042);
		wb(1'b0, ADR_CTRL, 32'h0);
		chk(rd, 32'h6042);
		wb(1'b1, ADR_CTRL, 32'h4042);
		wb(1'b1, ADR_KEY, 32'hAA);
		wb(1'b1, ADR_KEY, 32'h55);
		wb(1'b1, ADR_CTRL, 32'hC042);
		wb(1'b0, ADR_CTRL, 32'h0);
		chk(rd, 32'h6042);
		$display("unlock guard done");
	endtask

	task automatic t_codes();
		logic [15:0] tbl [8];
		tbl = '{16'hC00F, 16'hC043, 16'hC002, 16'hC041, 16'hC005, 16'hC047,
			16'hC04F, 16'hC000};
		foreach (tbl[i])
			op(tbl[i], 1'b1, 16'h0, 2'h0, 24'h0, 1'b0);
		$display("no-operation codes done");
	endtask

	task automatic t_word();
		base = reqs;
		wb(1'b1, ADR_PAGE, 32'h02);
		wb(1'b1, ADR_LADDR, 32'h0204);
		wb(1'b1, ADR_LDATA, 32'h123456);
		repeat (3) @(posedge clk_i);
		chk({16'h0, reqs}, {16'h0, base});
		wb(1'b1, ADR_LADDR, 32'h0204);
		op(16'hC003, 1'b1, 16'h1, 2'h0, 24'h020204, 1'b0);
		chk({8'h0, mdata}, 32'h123456);
		$display("word program done");
	endtask

	task automatic t_row();
		wb(1'b1, ADR_PAGE, 32'h01);
		wb(1'b1, ADR_LADDR, 32'h0100);
		for (int i = 0; i < 64; i++)
			wb(1'b1, ADR_LDATA, 32'hA50000 + i);
		wb(1'b0, ADR_LADDR, 32'h0);
		chk(rd, 32'h0180);
		wb(1'b1, ADR_LADDR, 32'h0100);
		op(16'hC001, 1'b1, 16'd64, 2'h0, 24'h01017E, 1'b0);
		chk({8'h0, mdata}, 32'hA5003F);
		$display("row program done");
	endtask

	task automatic t_bulk();
		serial <= 1'b1;
		op(16'hC04F, 1'b1, 16'h1, 2'h2, 24'h0, 1'b0);
		serial <= 1'b0;
		$display("bulk erase done");
	endtask

	task automatic t_fail();
		fail <= 1'b1;
		op(16'hC042, 1'b1, 16'h1, 2'h1, 24'h010000, 1'b1);
		fail <= 1'b0;
		pulse_warm();
		wb(1'b0, ADR_CTRL, 32'h0);
		chk(rd, 32'h6042);
		wb(1'b1, ADR_CTRL, 32'h4042);
		unlock();
		wb(1'b0, ADR_STAT, 32'h0);
		chk(rd, 32'h2);
		pulse_warm();
		wb(1'b0, ADR_STAT, 32'h0);
		chk(rd, 32'h0);
		wb(1'b1, ADR_CTRL, 32'hC042);
		wb(1'b0, ADR_CTRL, 32'h0);
		chk(rd, 32'h6042);
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, ADR_CTRL, 32'h0);
		chk(rd, 32'h0);
		$display("failure and warm reset done");
	endtask

	initial
	begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_erase();
		t_guard();
		t_codes();
		t_word();
		t_row();
		t_bulk();
		t_fail();
		test_done();
	end
endmodule
